// ---- bench/trig_seq_checker.sv ----
// port assertions for the trigger sequencer
`timescale 1ns/10ps
module trig_seq_checker
  import trig_seq_pkg::*;
(
  input wire logic mclk, // sample clock
  input wire logic sys_rst, // sync reset
  input wire logic [trig_seq_pkg::NUM_TU-1:0] tu_match, // unit matches
  input wire trig_seq_pkg::bus_req_type bus_req, // register request
  input wire logic [31:0] rdata, // read data
  input wire logic trig_fire, // module trigger
  input wire logic trig_out_pin, // pin trigger-out
  input wire logic trig_out_net, // net trigger-out
  input wire logic armed // armed level
);
  logic [31:0] tout_q;
  logic [15:0] en_q;
  logic [1:0] tw_q;
  logic [16:0] run_q;
  logic [16:0] w1;
  logic wr_tout, pin_act, net_act, pin_on, net_on, quiet;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // shadow of trigger-out and enable words; output levels lag a write, so skip two cycles
  assign wr_tout = bus_req.wr && bus_req.addr == ADDR_TOUT;
  assign pin_act = trig_out_pin != tout_q[TOUT_POL];
  assign net_act = trig_out_net != tout_q[TOUT_POL];
  assign pin_on = tout_q[TOUT_EN] && !tout_q[TOUT_ROUTE_LO];
  assign net_on = tout_q[TOUT_EN] && ^tout_q[TOUT_ROUTE_LO+:2];
  assign quiet = tw_q == 2'b00 && !wr_tout;
  assign w1 = tout_q[31:16] == PW_ZERO ? 17'h0_0001 : {1'b0, tout_q[31:16]};
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tout_q <= 32'h0000_0000;
      en_q <= 16'h0000;
      tw_q <= 2'b00;
      run_q <= 17'h0_0000;
    end else begin
      if (wr_tout) tout_q <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == ADDR_EN && !armed) en_q <= bus_req.wdata[15:0];
      tw_q <= {tw_q[0], wr_tout};
      run_q <= pin_act ? run_q + 17'h0_0001 : 17'h0_0000;
    end
  end
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_fire_single: assert property (trig_fire |=> !trig_fire)
    else $error("module trigger longer than one cycle");
  a_fire_disarms: assert property (trig_fire |-> ##[0:2] !armed)
    else $error("still armed after trigger");
  a_fire_gated: assert property (en_q == 16'h0000 && $past(en_q, 3) == 16'h0000 |-> !trig_fire)
    else $error("trigger with all expressions disabled");
  a_pin_on_fire: assert property (trig_fire && pin_on && quiet |-> pin_act)
    else $error("pin trigger-out missing");
  a_net_on_fire: assert property (trig_fire && net_on && quiet |-> net_act)
    else $error("net trigger-out missing");
  a_net_route_off: assert property (quiet && !net_on |-> !net_act)
    else $error("net trigger-out active when not routed");
  a_pin_cause: assert property (quiet && $rose(pin_act) |-> trig_fire)
    else $error("pin trigger-out without trigger");
  a_width_min: assert property (quiet && $fell(pin_act) |-> run_q >= w1)
    else $error("trigger-out pulse too short");
  // the armed output trails the arm register by one cycle
  a_arm_takes: assert property (bus_req.wr && bus_req.addr == ADDR_CTRL
    && bus_req.wdata[CTRL_ARM] |-> ##2 armed) else $error("arm write not taken");
  c_fire: cover property (trig_fire);
  c_long_pulse: cover property (pin_act && run_q > 17'h0_0002);
  c_net: cover property (net_act);
endmodule
bind trig_seq trig_seq_checker chk (.mclk(mclk), .sys_rst(sys_rst), .tu_match(tu_match),
  .bus_req(bus_req), .rdata(rdata), .trig_fire(trig_fire), .trig_out_pin(trig_out_pin),
  .trig_out_net(trig_out_net), .armed(armed));

// ---- bench/trig_seq_partner.sv ----
// far-side model: design-under-test unit matches and a sibling trigger-out consumer
`timescale 1ns/10ps
module trig_seq_partner (
  input wire logic mclk, // sample clock
  input wire logic drv, // bench script owns units 2:0
  input wire logic [2:0] pat, // scripted unit levels
  input wire logic net_in, // trigger-out from the sequencer
  output logic [7:0] tu_match, // unit matches into the sequencer
  output logic net_sync // trigger-out after the sibling synchroniser
);
  logic [7:0] noise_q = 8'h00;
  logic [1:0] sync_q = 2'b00;
  // unscripted units take a fresh random level every clock so a masked unit can never pass by luck
  always_ff @(posedge mclk) begin
    noise_q <= 8'($urandom);
  end
  assign tu_match = {noise_q[7:3], drv ? pat : noise_q[2:0]};
  // two flops, as a sibling on an unrelated clock needs before using the trigger
  always_ff @(posedge mclk) begin
    sync_q <= {sync_q[0], net_in};
  end
  assign net_sync = sync_q[1];
endmodule

// ---- bench/trig_seq_tb_top.sv ----
// self-checking bench for the trigger sequencer
`timescale 1ns/10ps
module trig_seq_tb_top;
  import trig_seq_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic drv = 1'b0;
  logic [2:0] pat = 3'h0;
  bus_req_type bus_req = '0;
  logic [7:0] tu_match;
  logic [31:0] rdata;
  logic trig_fire, trig_out_pin, trig_out_net, armed, net_sync;
  logic [2:0] pa[48];
  logic [15:0] en;
  int error_cnt = 0;
  int compares = 0;
  int e;
  always #5 mclk = ~mclk;
  trig_seq uut (.mclk(mclk), .sys_rst(sys_rst), .tu_match(tu_match), .bus_req(bus_req),
    .rdata(rdata), .trig_fire(trig_fire), .trig_out_pin(trig_out_pin),
    .trig_out_net(trig_out_net), .armed(armed));
  trig_seq_partner far (.mclk(mclk), .drv(drv), .pat(pat), .net_in(trig_out_net),
    .tu_match(tu_match), .net_sync(net_sync));
  task automatic check(input logic ok, input string msg);
    compares++;
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // bus cycles: one strobe cycle, read data checked in the slot after it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 check(rdata === x, "read data");
  endtask
  task automatic setp(input int u, input int idx[$]);
    foreach (idx[k]) pa[idx[k]][u] = 1'b1;
  endtask
  function automatic logic comb(comb_op_type op, logic [1:0] v);
    return op == OP_AND ? &v : op == OP_OR ? |v : op == OP_XOR ? ^v : 1'b1;
  endfunction
  // reference sequencer: cycle of the hit that completes the final count, 999 if none
  function automatic int ref_hit(comb_op_type op, link_type l0, link_type l1, int c0, int c1,
      int last, int fc);
    int s = 0;
    int c = 0;
    int h = 0;
    logic m;
    logic [2:0] p;
    // script plays 48 cycles, then units rest low while a pending delay may still finish
    for (int i = 0; i < 54; i++) begin
      p = i < 48 ? pa[i] : 3'h0;
      m = s ? (l1 == LK_DELAY || p[2]) : comb(op, p[1:0]);
      if (s && l1 == LK_NEXT && !m) begin
        s = 0;
      end else if (m) begin
        c++;
        if (c >= (s ? c1 : c0)) begin
          c = 0;
          if (s == last) begin
            s = 0;
            h++;
            if (h == fc) return i;
          end else s = 1;
        end
      end else if (!s && l0 == LK_CONSEC) c = 0;
    end
    return 999;
  endfunction
  // program one expression, arm, play the script and watch both trigger-outs
  task automatic run(int e, logic [15:0] en, comb_op_type op, link_type l0, link_type l1,
      int c0, int c1, int last, logic fen, int fc, logic [31:0] tout);
    int x;
    int w1;
    int np;
    int nn;
    logic [1:0] nh;
    x = en[e] ? ref_hit(op, l0, l1, c0, c1, last, fen ? fc : 1) : 999;
    w1 = tout[31:16] == 16'h0000 ? 1 : int'(tout[31:16]);
    np = 0;
    nn = 0;
    nh = 2'b00;
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(STEP_BASE + 8'(e * NUM_STEP), {12'(c0), l0, op, 8'h03, 8'h03});
    wr(STEP_BASE + 8'(e * NUM_STEP + 1), {12'(c1), l1, l1 == LK_DELAY ? OP_TRUE : OP_AND,
      8'h04, 8'h04});
    wr(ADDR_DEPTH, {24'h00_0000, 4'(e), 2'b00, 2'(last)});
    wr(ADDR_EN, {16'h0000, en});
    wr(ADDR_FINAL, 32'(fc));
    wr(ADDR_TOUT, tout);
    // first pattern stands before arming, as the engines look at the first edge after it
    drv <= 1'b1;
    pat <= pa[0];
    wr(ADDR_CTRL, {30'h0000_0000, fen, 1'b1});
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      pat <= i < 47 ? pa[i + 1] : 3'h0;
      #1 check(trig_fire === (i == x + 2), "module trigger timing");
      if (i > 1) check(net_sync === nh[1], "synchronised trigger-out");
      nh = {nh[0], trig_out_net};
      np += int'(trig_out_pin !== tout[TOUT_POL]);
      nn += int'(trig_out_net !== tout[TOUT_POL]);
    end
    drv <= 1'b0;
    check(armed === (x == 999), "arm level after run");
    check(np === (x < 999 && tout[3] && !tout[1] ? w1 : 0), "pin pulse");
    check(nn === (x < 999 && tout[3] && ^tout[2:1] ? w1 : 0), "net pulse");
    // disarm, then park this slot on an xor over no units so later runs see only their own
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(STEP_BASE + 8'(e * NUM_STEP), 32'h0002_0000);
  endtask
  initial begin
    #100us;
    error_cnt++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hc3b6e5dd));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    #1 check({trig_fire, trig_out_pin, trig_out_net, armed} === 4'h0, "reset levels");
    rd(ADDR_STATUS, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    // reset step words match on every clock; park every slot on a term that never matches
    for (int k = 0; k < NUM_EXPR; k++) wr(STEP_BASE + 8'(k * NUM_STEP), 32'h0002_0000);
    pa = '{default: 3'h0};
    setp(0, '{2, 10});
    setp(2, '{4, 11});
    run(0, 16'h0001, OP_OR, LK_THEN, LK_NEXT, 1, 1, 1, 0, 1, 32'h0003_0008);
    pa = '{default: 3'h0};
    setp(0, '{1, 2, 4, 5, 6});
    setp(2, '{5, 9});
    run(5, 16'h0020, OP_OR, LK_CONSEC, LK_THEN, 3, 1, 1, 0, 1, 32'h0002_000b);
    pa = '{default: 3'h0};
    setp(0, '{3});
    run(15, 16'h8000, OP_OR, LK_THEN, LK_DELAY, 1, 5, 1, 0, 1, 32'h0000_000c);
    setp(0, '{9, 20});
    run(3, 16'h0008, OP_OR, LK_THEN, LK_THEN, 3, 1, 0, 0, 1, 32'h0004_000e);
    run(3, 16'hfff7, OP_OR, LK_THEN, LK_THEN, 1, 1, 0, 0, 1, 32'h0000_0008);
    run(3, 16'h0008, OP_OR, LK_THEN, LK_THEN, 1, 1, 0, 1, 3, 32'h0001_0008);
    run(3, 16'h0008, OP_OR, LK_THEN, LK_THEN, 1, 1, 0, 0, 3, 32'h0001_0008);
    pa = '{default: 3'h0};
    setp(0, '{1, 5});
    repeat (2) run(7, 16'h0080, OP_OR, LK_THEN, LK_THEN, 3, 1, 0, 0, 1, 32'h0000_0008);
    repeat (16) begin
      foreach (pa[k]) pa[k] = 3'($urandom) & 3'($urandom);
      e = $urandom_range(0, 15);
      en = 16'($urandom);
      if ($urandom_range(0, 3) > 0) en[e] = 1'b1;
      run(e, en, comb_op_type'($urandom_range(0, 3)), $urandom_range(0, 1) ? LK_CONSEC : LK_THEN,
        $urandom_range(0, 1) ? LK_DELAY : LK_THEN, $urandom_range(1, 4), $urandom_range(1, 4),
        $urandom_range(0, 1), 1'($urandom_range(0, 1)), $urandom_range(1, 3),
        {16'($urandom_range(0, 7)), 12'h000, 4'($urandom_range(0, 15))});
    end
    print_verdict();
  end
endmodule

// ---- design/trig_seq.sv ----
// trigger sequencer: expressions, final event counter and trigger-out
`timescale 1ns/10ps
// Function
// - a # count passes once the term matched that many clocks, gaps allowed
// - an always-true term with a count waits that many contiguous clocks
// - a count qualifies a whole step term, never a fragment
// - each expression has its own sequence counter of fixed build width
// - up to sixteen independent expressions each evaluate their own equation
// - each expression has a run-time enable; disabled ones never trigger
// - steps combine unit matches combinationally and chain sequentially
// - optional final counter counts combined triggers, fires at programmed count
// - final counter maximum is a build-time power of two, 2 to 65536
// - final count reprogrammable up to the maximum, all values accepted
// - with final counter off, first combined trigger fires the module trigger
// - the module offers an optional trigger-out signal
// - trigger-out routes to pin, internal net, or both
// - trigger-out polarity is selectable high or low
// - trigger-out stays active at least the configured clocks, zero allowed
// - on single-core targets trigger-out is pin only
// - a next step must match on the very next clock or restart
// - a then step checks no earlier than one clock after previous match
// - a consecutive count needs back-to-back matches, a gap restarts
module trig_seq
  import trig_seq_pkg::*;
#(
  parameter bit SINGLE_CORE = 1'b0       // restricts trigger-out to the pin
) (
  input wire logic mclk,                           // 100 MHz sample clock
  input wire logic sys_rst,                        // synchronous reset, active high
  input wire logic [trig_seq_pkg::NUM_TU-1:0] tu_match, // trigger unit matches, same clock
  input wire trig_seq_pkg::bus_req_type bus_req,   // register port request
  output logic [31:0] rdata,                       // read data, cycle after read strobe
  output logic trig_fire,                          // module trigger, one-cycle pulse
  output logic trig_out_pin,                       // trigger-out towards the pin
  output logic trig_out_net,                       // trigger-out towards sibling modules
  output logic armed                               // triggering is active
);
  import trig_seq_pkg::*;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic arm_q;
  logic fen_q;
  logic [NUM_EXPR-1:0] en_q;
  logic [FINAL_CW-1:0] fcount_q;
  logic tpol_q;
  route_type troute_q;
  logic ten_q;
  logic [PW_CW-1:0] tpw_q;
  step_cfg_type step_q [NUM_EXPR][NUM_STEP];
  logic [$clog2(NUM_STEP)-1:0] depth_q [NUM_EXPR];
  logic hit_q;

  // decode the step word and zero-extend the 12-bit count to the counter width
  function automatic step_cfg_type to_step(input logic [31:0] w);
    step_cfg_type s;
    s.mask = w[ST_MASK_LO +: NUM_TU];
    s.pol = w[ST_POL_LO +: NUM_TU];
    s.op = comb_op_type'(w[ST_OP_LO +: 2]);
    s.link = link_type'(w[ST_LINK_LO +: 2]);
    s.count = {{(SEQ_CW-ST_CNT_W){1'b0}}, w[ST_CNT_LO +: ST_CNT_W]};
    return s;
  endfunction

  // one whole-step term from unit matches; count applies only to this result
  function automatic logic term_of(input step_cfg_type s, input logic [NUM_TU-1:0] m);
    logic [NUM_TU-1:0] lv;
    lv = ~(m ^ s.pol) | ~s.mask;
    unique case (s.op)
      OP_AND: term_of = &lv;
      OP_OR: term_of = |(~(m ^ s.pol) & s.mask);
      OP_XOR: term_of = ^(m & s.mask);
      OP_TRUE: term_of = 1'b1;
    endcase
  endfunction

  // clamp a final count into 1..FINAL_MAX
  function automatic logic [FINAL_CW-1:0] clamp_final(input logic [31:0] w);
    logic [FINAL_CW-1:0] v;
    v = w[FINAL_CW-1:0];
    if (w[31:FINAL_CW] != '0 || v > FINAL_MAX) v = FINAL_MAX;
    if (v == '0) v = FCNT_ONE;
    return v;
  endfunction

  wire wr_ctrl = bus_req.wr && bus_req.addr == ADDR_CTRL;
  wire wr_en = bus_req.wr && bus_req.addr == ADDR_EN;
  wire wr_final = bus_req.wr && bus_req.addr == ADDR_FINAL;
  wire wr_tout = bus_req.wr && bus_req.addr == ADDR_TOUT;
  wire wr_depth = bus_req.wr && bus_req.addr == ADDR_DEPTH;
  wire is_step = bus_req.addr >= STEP_BASE;
  wire [ADDR_W-1:0] step_off = bus_req.addr - STEP_BASE;
  wire step_hit = is_step && step_off < ADDR_W'(NUM_EXPR*NUM_STEP);
  wire [3:0] step_e = step_off[2 +: 4];
  wire [1:0] step_s = step_off[1:0];
  wire arm_rise = wr_ctrl && bus_req.wdata[CTRL_ARM] && !arm_q;
  wire arm_start = arm_rise;   // arming restarts evaluation from scratch

  // control registers; expression and final enables only change while disarmed
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      arm_q <= 1'b0;
      fen_q <= 1'b0;
      en_q <= '0;
      fcount_q <= FCNT_ONE;
      tpol_q <= 1'b0;
      troute_q <= RT_IO;
      ten_q <= 1'b0;
      tpw_q <= PW_ZERO;
    end else begin
      if (wr_ctrl) begin
        arm_q <= bus_req.wdata[CTRL_ARM];
        if (!arm_q) fen_q <= bus_req.wdata[CTRL_FEN];
      end else if (hit_q) begin
        arm_q <= 1'b0;   // one capture per arming
      end
      if (wr_en && !arm_q) en_q <= bus_req.wdata[NUM_EXPR-1:0];
      if (wr_final) fcount_q <= clamp_final(bus_req.wdata);
      if (wr_tout) begin
        tpol_q <= bus_req.wdata[TOUT_POL];
        troute_q <= SINGLE_CORE ? RT_IO : route_type'(bus_req.wdata[TOUT_ROUTE_LO +: 2]);
        ten_q <= bus_req.wdata[TOUT_EN];
        tpw_q <= bus_req.wdata[TOUT_PW_LO +: PW_CW];
      end
    end
  end

  // step table and per-expression depth
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int e = 0; e < NUM_EXPR; e++) begin
        depth_q[e] <= '0;
        for (int s = 0; s < NUM_STEP; s++) step_q[e][s] <= '0;
      end
    end else begin
      if (bus_req.wr && step_hit && !arm_q) step_q[step_e][step_s] <= to_step(bus_req.wdata);
      if (wr_depth && !arm_q) depth_q[bus_req.wdata[7:4]] <= bus_req.wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // expression engines
  // ----------------------------------------------------------------
  logic [$clog2(NUM_STEP)-1:0] stp_q [NUM_EXPR];
  logic [SEQ_CW-1:0] cnt_q [NUM_EXPR];     // one counter per expression
  logic [NUM_EXPR-1:0] adv_q;              // previous step just matched
  logic [NUM_EXPR-1:0] ex_hit;

  // each expression walks its steps; THEN waits a clock after the last match
  always_ff @(posedge mclk) begin
    if (sys_rst || arm_start) begin
      for (int e = 0; e < NUM_EXPR; e++) begin
        stp_q[e] <= '0;
        cnt_q[e] <= '0;
      end
      adv_q <= '0;
    end else begin
      for (int e = 0; e < NUM_EXPR; e++) begin : engine
        step_cfg_type c;
        logic t;
        logic done;
        logic [SEQ_CW-1:0] need;
        c = step_q[e][stp_q[e]];
        t = term_of(c, tu_match);
        need = (c.count == '0) ? CNT_ONE : c.count;
        done = 1'b0;
        adv_q[e] <= 1'b0;
        if (arm_q && en_q[e]) begin
          unique case (c.link)
            LK_THEN: begin
              if (t) begin
                if (cnt_q[e] + CNT_ONE >= need) done = 1'b1;
                else cnt_q[e] <= cnt_q[e] + CNT_ONE;
              end
            end
            LK_NEXT, LK_CONSEC: begin
              if (t) begin
                if (cnt_q[e] + CNT_ONE >= need) done = 1'b1;
                else cnt_q[e] <= cnt_q[e] + CNT_ONE;
              end else if (adv_q[e] || cnt_q[e] != '0) begin
                stp_q[e] <= '0;
                cnt_q[e] <= '0;
              end
            end
            LK_DELAY: begin
              if (cnt_q[e] + CNT_ONE >= need) done = 1'b1;
              else cnt_q[e] <= cnt_q[e] + CNT_ONE;
            end
          endcase
          if (done) begin
            cnt_q[e] <= '0;
            adv_q[e] <= 1'b1;
            if (stp_q[e] == depth_q[e]) stp_q[e] <= '0;
            else stp_q[e] <= stp_q[e] + 1'b1;
          end
        end
      end
    end
  end

  // last step completion of an enabled expression is its trigger
  always_comb begin
    for (int e = 0; e < NUM_EXPR; e++) begin
      ex_hit[e] = adv_q[e] && stp_q[e] == '0 && en_q[e];
    end
  end

  // ----------------------------------------------------------------
  // final event counter
  // ----------------------------------------------------------------
  logic [FINAL_CW-1:0] fcnt_q;
  wire any_hit = |ex_hit && arm_q && !hit_q;   // one hit per arming; disarm lands a cycle late
  wire [FINAL_CW-1:0] f_need = fen_q ? fcount_q : FCNT_ONE;
  wire f_reach = any_hit && (fcnt_q + FCNT_ONE >= f_need);

  // counts combined expression triggers up to the programmed value
  always_ff @(posedge mclk) begin
    if (sys_rst || arm_start) begin
      fcnt_q <= '0;
      hit_q <= 1'b0;
    end else begin
      hit_q <= f_reach;
      if (f_reach) fcnt_q <= '0;
      else if (any_hit) fcnt_q <= fcnt_q + FCNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // trigger-out with minimum width and polarity
  // ----------------------------------------------------------------
  logic [PW_CW-1:0] pw_q;
  logic tact_q;
  wire tact_d = ten_q && (hit_q || (tact_q && pw_q > CNT_ONE));

  // a zero or one width still gives a single-cycle pulse
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tact_q <= 1'b0;
      pw_q <= PW_ZERO;
    end else begin
      tact_q <= tact_d;
      if (hit_q) pw_q <= tpw_q;
      else if (pw_q != PW_ZERO) pw_q <= pw_q - CNT_ONE;
    end
  end

  wire lvl = tact_d ^ tpol_q;    // next state, so trigger-out lines up with trig_fire
  wire to_pin = troute_q == RT_IO || troute_q == RT_BOTH;
  wire to_net = !SINGLE_CORE && (troute_q == RT_NET || troute_q == RT_BOTH);

  // registered outputs; the net copy is synchronised by its consumer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trig_out_pin <= 1'b0;
      trig_out_net <= 1'b0;
      trig_fire <= 1'b0;
      armed <= 1'b0;
      rdata <= '0;
    end else begin
      trig_out_pin <= to_pin ? lvl : tpol_q;
      trig_out_net <= to_net ? lvl : tpol_q;
      trig_fire <= hit_q;
      armed <= arm_q;
      rdata <= '0;
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          ADDR_CTRL: rdata <= {30'h0000_0000, fen_q, arm_q};
          ADDR_EN: rdata <= {16'h0000, en_q};
          ADDR_FINAL: rdata <= {15'h0000, fcount_q};
          ADDR_TOUT: rdata <= {tpw_q, 12'h000, ten_q, troute_q, tpol_q};
          ADDR_STATUS: rdata <= {15'h0000, fcnt_q};
          default: rdata <= '0;
        endcase
      end
    end
  end
endmodule

// ---- design/trig_seq_pkg.sv ----
// package: constants and carriers for the trigger sequencer
package trig_seq_pkg;
  localparam int NUM_EXPR = 16;          // expression slots
  localparam int NUM_TU = 8;             // trigger unit match inputs
  localparam int NUM_STEP = 4;           // sequence depth per expression
  localparam int SEQ_CW = 16;            // sequence counter width
  localparam int FINAL_CW = 17;          // final event counter width, holds 65536
  localparam int PW_CW = 16;             // minimum pulse width counter width
  localparam logic [FINAL_CW-1:0] FINAL_MAX = 17'h1_0000; // build-time final maximum
  localparam logic [SEQ_CW-1:0] SEQ_MAX = 16'hffff;        // build-time sequence maximum
  localparam logic [SEQ_CW-1:0] CNT_ONE = 16'h0001;
  localparam logic [FINAL_CW-1:0] FCNT_ONE = 17'h0_0001;
  localparam logic [PW_CW-1:0] PW_ZERO = 16'h0000;
  localparam int ADDR_W = 8;
  // register map: expression slot e step s at STEP_BASE + e*NUM_STEP + s
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_EN = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_FINAL = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_TOUT = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DEPTH = 8'h05;
  localparam logic [ADDR_W-1:0] STEP_BASE = 8'h40;
  // ctrl bits
  localparam int CTRL_ARM = 0;
  localparam int CTRL_FEN = 1;
  localparam int TOUT_POL = 0;           // 1 = active low
  localparam int TOUT_ROUTE_LO = 1;      // 2-bit route field
  localparam int TOUT_EN = 3;
  localparam int TOUT_PW_LO = 16;
  // step word layout
  localparam int ST_MASK_LO = 0;         // which units take part
  localparam int ST_POL_LO = 8;          // required level of each unit
  localparam int ST_OP_LO = 16;          // 2-bit combine op
  localparam int ST_LINK_LO = 18;        // 2-bit link/count mode
  localparam int ST_CNT_LO = 20;         // 12-bit count
  localparam int ST_CNT_W = 12;

  typedef enum logic [1:0] {OP_AND, OP_OR, OP_XOR, OP_TRUE} comb_op_type;
  typedef enum logic [1:0] {LK_THEN, LK_NEXT, LK_CONSEC, LK_DELAY} link_type;
  typedef enum logic [1:0] {RT_IO, RT_NET, RT_BOTH, RT_NONE} route_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic [SEQ_CW-1:0] count;
    link_type link;
    comb_op_type op;
    logic [NUM_TU-1:0] pol;
    logic [NUM_TU-1:0] mask;
  } step_cfg_type;
endpackage
